// File: apsel_pkg.sv
// package for the alternate pin select block: offsets, fields, resets, carriers
package apsel_pkg;
    // ******************************************************************
    // register map
    // ******************************************************************
    localparam logic [3:0] apsel_addr_select = 4'h0; // select register byte address
    localparam logic [3:0] apsel_addr_status = 4'h4; // routed-level status byte address
    localparam logic [7:0] apsel_select_reset = 8'h00; // every function on its default pin
    localparam logic [7:0] apsel_select_mask = 8'h1f; // implemented bits 4..0
    // ******************************************************************
    // field positions
    // ******************************************************************
    localparam int apsel_bit_pwm2_b = 4;
    localparam int apsel_bit_latch_inv = 3;
    localparam int apsel_bit_cmp2 = 2;
    localparam int apsel_bit_ss = 1;
    localparam int apsel_bit_capture2 = 0;
    localparam int apsel_nfunc = 5;
    // ******************************************************************
    // pin carriers
    // ******************************************************************
    // one entry per pin the block can drive
    typedef struct packed {
        logic rc0;
        logic rd2;
        logic ra5;
        logic ra0;
        logic rc1;
        logic rb3;
    } apsel_pins_t;
    // peripheral signals heading to the pins
    typedef struct packed {
        logic pwm2_output_b;
        logic latch_inverted_output;
        logic comparator2_output;
        logic capture2_out;
    } apsel_periph_out_t;
endpackage : apsel_pkg

// File: apsel_top.sv
// alternate pin select: register over classic wishbone plus pin routing
// Behaviour
// - bit 4 zero puts pwm b on rc0
// - bit 4 one moves pwm b to rd2
// - bit 3 zero puts latch nq on ra5 while bit 2 is one
// - bit 2 zero puts comparator2 on ra5
// - bit 2 one moves comparator2 to ra0
// - bit 1 zero takes slave select from ra5
`timescale 1ns/1ps
`default_nettype none
module apsel_top #(
    parameter int data_width = 32 // wishbone data width
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [data_width-1:0] wb_dat_i,
    output logic [data_width-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // peripheral side
    input wire apsel_pkg::apsel_periph_out_t periph_out,
    input wire logic periph_pwm2_b_en,
    output logic slave_select_in,
    output logic capture2_in,
    // pin side
    input wire apsel_pkg::apsel_pins_t pin_in,
    output apsel_pkg::apsel_pins_t pin_out,
    output apsel_pkg::apsel_pins_t pin_oe_n
);
    // ******************************************************************
    // elaboration check
    // ******************************************************************
    // byte lane 0 carries the register; the bus must be 32 bits wide
    if (data_width != 32) begin : g_bad_width
        $error("apsel_top: data_width must be 32");
    end
    // ******************************************************************
    // register and bus slave
    // ******************************************************************
    logic [7:0] alternate_pin_select; // the select register
    logic [7:0] next_alternate_pin_select;
    logic [data_width-1:0] next_wb_dat_o;
    logic next_wb_ack_o;
    logic next_wb_err_o;
    logic req; // request pending, not yet answered
    logic hit_sel; // address decodes the select register
    logic hit_stat; // address decodes the status byte
    apsel_pkg::apsel_pins_t next_pin_out;
    apsel_pkg::apsel_pins_t next_pin_oe_n;
    logic next_slave_select_in;
    logic next_capture2_in;
    logic [apsel_pkg::apsel_nfunc-1:0] status_lvl; // routed levels for readback

    // a fresh request only; the cycle after ack is ignored so no double write
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_sel = (wb_adr_i == apsel_pkg::apsel_addr_select);
    assign hit_stat = (wb_adr_i == apsel_pkg::apsel_addr_status);

    // next bus answer and register value
    always_comb begin
        next_alternate_pin_select = alternate_pin_select;
        next_wb_dat_o = '0;
        next_wb_ack_o = 1'b0;
        next_wb_err_o = 1'b0;
        // a write lands at the edge where the master sees ack, so a cycle
        // abandoned before ack leaves the routing alone
        // only lane 0 holds bits; reserved bits stay zero
        if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit_sel
            && wb_sel_i[0]) begin
            next_alternate_pin_select = wb_dat_i[7:0] & apsel_pkg::apsel_select_mask;
        end
        if (req) begin
            if (hit_sel) begin
                next_wb_ack_o = 1'b1;
                // reads return the byte as it stands when the request is taken
                next_wb_dat_o[7:0] = alternate_pin_select;
            end else if (hit_stat) begin
                // status is read only; writes are acked and dropped
                next_wb_ack_o = 1'b1;
                next_wb_dat_o[apsel_pkg::apsel_nfunc-1:0] = status_lvl;
            end else begin
                // unmapped address answers with err
                next_wb_err_o = 1'b1;
            end
        end
    end

    // register the bus state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alternate_pin_select <= apsel_pkg::apsel_select_reset;
            wb_dat_o <= '0;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            alternate_pin_select <= next_alternate_pin_select;
            wb_dat_o <= next_wb_dat_o;
            wb_ack_o <= next_wb_ack_o;
            wb_err_o <= next_wb_err_o;
        end
    end

    // ******************************************************************
    // pin routing
    // ******************************************************************
    // select bits with their coined names
    logic pwm2_b_pin_sel;
    logic latch_inv_out_pin_sel;
    logic comparator2_out_pin_sel;
    logic slave_select_pin_sel;
    logic capture2_pin_sel;
    assign pwm2_b_pin_sel = alternate_pin_select[apsel_pkg::apsel_bit_pwm2_b];
    assign latch_inv_out_pin_sel = alternate_pin_select[apsel_pkg::apsel_bit_latch_inv];
    assign comparator2_out_pin_sel = alternate_pin_select[apsel_pkg::apsel_bit_cmp2];
    assign slave_select_pin_sel = alternate_pin_select[apsel_pkg::apsel_bit_ss];
    assign capture2_pin_sel = alternate_pin_select[apsel_pkg::apsel_bit_capture2];

    // two-way pick between default and alternate pin level; used by the
    // readback and by both peripheral inputs
    function automatic logic pick_level(input logic alt, input logic alt_lvl,
        input logic dflt_lvl);
        return alt ? alt_lvl : dflt_lvl;
    endfunction : pick_level

    // readback of what the routing presents: ss input, capture input, pin levels
    assign status_lvl = {pick_level(pwm2_b_pin_sel, pin_in.rd2, pin_in.rc0),
                         pick_level(latch_inv_out_pin_sel, pin_in.ra0, pin_in.ra5),
                         pick_level(comparator2_out_pin_sel, pin_in.ra0, pin_in.ra5),
                         slave_select_in, capture2_in};

    // next pin drive; comparator wins over latch when both claim one pin
    always_comb begin
        next_pin_out = '0;
        next_pin_oe_n = '1;
        // pwm b on rc0 or rd2, only while the pwm drives it
        if (periph_pwm2_b_en) begin
            if (!pwm2_b_pin_sel) begin
                next_pin_out.rc0 = periph_out.pwm2_output_b;
                next_pin_oe_n.rc0 = 1'b0;
            end else begin
                next_pin_out.rd2 = periph_out.pwm2_output_b;
                next_pin_oe_n.rd2 = 1'b0;
            end
        end
        // latch inverted output
        if (!latch_inv_out_pin_sel) begin
            next_pin_out.ra5 = periph_out.latch_inverted_output;
            next_pin_oe_n.ra5 = 1'b0;
        end else begin
            next_pin_out.ra0 = periph_out.latch_inverted_output;
            next_pin_oe_n.ra0 = 1'b0;
        end
        // comparator 2 output, assigned later so it has priority
        if (!comparator2_out_pin_sel) begin
            next_pin_out.ra5 = periph_out.comparator2_output;
            next_pin_oe_n.ra5 = 1'b0;
        end else begin
            next_pin_out.ra0 = periph_out.comparator2_output;
            next_pin_oe_n.ra0 = 1'b0;
        end
        // capture 2 output pin
        if (!capture2_pin_sel) begin
            next_pin_out.rc1 = periph_out.capture2_out;
            next_pin_oe_n.rc1 = 1'b0;
        end else begin
            next_pin_out.rb3 = periph_out.capture2_out;
            next_pin_oe_n.rb3 = 1'b0;
        end
        // inputs toward peripherals
        next_slave_select_in = pick_level(slave_select_pin_sel, pin_in.ra0,
            pin_in.ra5);
        next_capture2_in = pick_level(capture2_pin_sel, pin_in.rb3, pin_in.rc1);
    end

    // register the pin side; one cycle of latency keeps outputs glitch free
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin_out <= '0;
            pin_oe_n <= '1;
            slave_select_in <= 1'b1;
            capture2_in <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            slave_select_in <= next_slave_select_in;
            capture2_in <= next_capture2_in;
        end
    end

    // ******************************************************************
    // assertions
    // ******************************************************************
    property p_pwm_default;
        @(posedge sys_clk) disable iff (srst)
        (!pwm2_b_pin_sel && periph_pwm2_b_en) |=> (!pin_oe_n.rc0 && pin_oe_n.rd2
            && pin_out.rc0 == $past(periph_out.pwm2_output_b));
    endproperty
    a_pwm_default: assert property (p_pwm_default) else $error("pwm b not on rc0");
    property p_pwm_alt;
        @(posedge sys_clk) disable iff (srst)
        (pwm2_b_pin_sel && periph_pwm2_b_en) |=> (!pin_oe_n.rd2 && pin_oe_n.rc0
            && pin_out.rd2 == $past(periph_out.pwm2_output_b));
    endproperty
    a_pwm_alt: assert property (p_pwm_alt) else $error("pwm b not on rd2");
    property p_latch_default;
        @(posedge sys_clk) disable iff (srst)
        (!latch_inv_out_pin_sel && comparator2_out_pin_sel) |=> (!pin_oe_n.ra5
            && pin_out.ra5 == $past(periph_out.latch_inverted_output));
    endproperty
    a_latch_default: assert property (p_latch_default) else $error("latch not on ra5");
    property p_cmp_default;
        @(posedge sys_clk) disable iff (srst)
        !comparator2_out_pin_sel |=> (!pin_oe_n.ra5
            && pin_out.ra5 == $past(periph_out.comparator2_output));
    endproperty
    a_cmp_default: assert property (p_cmp_default) else $error("comparator not on ra5");
    property p_cmp_alt;
        @(posedge sys_clk) disable iff (srst)
        comparator2_out_pin_sel |=> (!pin_oe_n.ra0
            && pin_out.ra0 == $past(periph_out.comparator2_output));
    endproperty
    a_cmp_alt: assert property (p_cmp_alt) else $error("comparator not on ra0");
    property p_ss_default;
        @(posedge sys_clk) disable iff (srst)
        !slave_select_pin_sel |=> (slave_select_in == $past(pin_in.ra5));
    endproperty
    a_ss_default: assert property (p_ss_default) else $error("ss not from ra5");
    property p_ss_alt;
        @(posedge sys_clk) disable iff (srst)
        slave_select_pin_sel |=> (slave_select_in == $past(pin_in.ra0));
    endproperty
    a_ss_alt: assert property (p_ss_alt) else $error("ss not from ra0");
    property p_latch_alt;
        @(posedge sys_clk) disable iff (srst)
        (latch_inv_out_pin_sel && !comparator2_out_pin_sel) |=> (!pin_oe_n.ra0
            && pin_out.ra0 == $past(periph_out.latch_inverted_output));
    endproperty
    a_latch_alt: assert property (p_latch_alt) else $error("latch not on ra0");
    property p_ack_pulse;
        @(posedge sys_clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    // a released pwm leaves both of its pins to the port
    property p_pwm_idle;
        @(posedge sys_clk) disable iff (srst)
        !periph_pwm2_b_en |=> (pin_oe_n.rc0 && pin_oe_n.rd2);
    endproperty
    a_pwm_idle: assert property (p_pwm_idle) else $error("pwm b pin driven while idle");
    // capture unit output and input share one pin either way
    property p_cap_default;
        @(posedge sys_clk) disable iff (srst)
        !capture2_pin_sel |=> (!pin_oe_n.rc1 && pin_oe_n.rb3
            && pin_out.rc1 == $past(periph_out.capture2_out)
            && capture2_in == $past(pin_in.rc1));
    endproperty
    a_cap_default: assert property (p_cap_default) else $error("capture not on rc1");
    property p_cap_alt;
        @(posedge sys_clk) disable iff (srst)
        capture2_pin_sel |=> (!pin_oe_n.rb3 && pin_oe_n.rc1
            && pin_out.rb3 == $past(periph_out.capture2_out)
            && capture2_in == $past(pin_in.rb3));
    endproperty
    a_cap_alt: assert property (p_cap_alt) else $error("capture not on rb3");
    // ******************************************************************
    // bus assertions
    // ******************************************************************
    // every accepted request is answered in the next cycle
    property p_answer;
        @(posedge sys_clk) disable iff (srst)
        req |=> (wb_ack_o || wb_err_o);
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    // read data is the register as it stood when the request was taken
    property p_read_back;
        @(posedge sys_clk) disable iff (srst)
        (req && hit_sel && !wb_we_i) |=> (wb_dat_o[7:0] == $past(alternate_pin_select));
    endproperty
    a_read_back: assert property (p_read_back) else $error("select readback wrong");
    // a write seen with ack shows in the register one edge later, masked
    property p_write_lands;
        @(posedge sys_clk) disable iff (srst)
        (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit_sel && wb_sel_i[0])
            |=> (alternate_pin_select == (8'($past(wb_dat_i)) & apsel_pkg::apsel_select_mask));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("select write lost");
    // reserved bits 7..5 never hold a one
    property p_reserved_zero;
        @(posedge sys_clk) disable iff (srst)
        (alternate_pin_select & ~apsel_pkg::apsel_select_mask) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved select bit set");
    c_write_sel: cover property (@(posedge sys_clk) disable iff (srst)
        req && hit_sel && wb_we_i ##1 wb_ack_o);
    c_pwm_move: cover property (@(posedge sys_clk) disable iff (srst)
        !pwm2_b_pin_sel ##1 pwm2_b_pin_sel);
    c_err: cover property (@(posedge sys_clk) disable iff (srst) wb_err_o);
    c_status_read: cover property (@(posedge sys_clk) disable iff (srst)
        req && hit_stat && !wb_we_i ##1 wb_ack_o);
    c_ss_alt: cover property (@(posedge sys_clk) disable iff (srst) slave_select_pin_sel);
endmodule : apsel_top
`default_nettype wire

// File: apsel_pin_model.sv
// port pin model: resolves each pin from the block drive and the board level
`timescale 1ns/1ps
`default_nettype none
module apsel_pin_model (
    // block side
    input wire apsel_pkg::apsel_pins_t drive,
    input wire apsel_pkg::apsel_pins_t drive_oe_n,
    // board side
    input wire apsel_pkg::apsel_pins_t board,
    output apsel_pkg::apsel_pins_t level
);
    // a released pin shows the board level, never the last driven value
    assign level = (drive & ~drive_oe_n) | (board & drive_oe_n);
endmodule : apsel_pin_model
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the alternate pin select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ****************************************
    // stimulus and observation signals
    // ****************************************
    logic sys_clk = 1'b0; // 100 mhz system clock
    logic srst = 1'b1; // held for six cycles at start
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // wishbone request
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r, rd;
    logic ack, err, fl, ss_in, cap_in;
    logic en = 1'b0; // pwm b drive enable
    apsel_pkg::apsel_periph_out_t periph = '0;
    apsel_pkg::apsel_pins_t ext = '0, p_in, p_out, p_oe_n;
    int n_errors = 0, checks = 0, seed = 32'h18316a09;
    logic [7:0] s; // select value last written
    logic [11:0] e; // expected {oe_n, out}
    logic [5:0] lv; // expected pin levels
    always #5 sys_clk = ~sys_clk;
    apsel_top uut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .wb_err_o(err), .periph_out(periph), .periph_pwm2_b_en(en),
        .slave_select_in(ss_in), .capture2_in(cap_in), .pin_in(p_in), .pin_out(p_out),
        .pin_oe_n(p_oe_n));
    apsel_pin_model pins (.drive(p_out), .drive_oe_n(p_oe_n), .board(ext), .level(p_in));
    // ****************************************
    // helpers
    // ****************************************
    task automatic complete_run();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    // one classic cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] be,
        input logic [7:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= be;
        dat_w <= {24'h0, d};
        i = 0;
        // ack is judged at the edge, so only values from before that edge count
        do begin
            @(posedge sys_clk);
            i++;
        end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
        if (i >= 20) begin
            n_errors++;
            complete_run();
        end
        rd = dat_r;
        fl = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge sys_clk);
    endtask : wb
    // expected routing: bits rc0,rd2,ra5,ra0,rc1,rb3 = 5..0
    function automatic logic [11:0] exp_pins(input logic [7:0] v, input logic [3:0] p,
        input logic pe);
        logic [5:0] oe, o;
        oe = 6'h3f;
        o = 6'h00;
        if (pe) begin
            oe[v[4] ? 4 : 5] = 1'b0;
            o[v[4] ? 4 : 5] = p[3];
        end
        oe[v[3] ? 2 : 3] = 1'b0;
        o[v[3] ? 2 : 3] = p[2];
        // comparator placed after the latch since it wins a shared pin
        oe[v[2] ? 2 : 3] = 1'b0;
        o[v[2] ? 2 : 3] = p[1];
        oe[v[0] ? 0 : 1] = 1'b0;
        o[v[0] ? 0 : 1] = p[0];
        return {oe, o};
    endfunction : exp_pins
    // expected status byte: pwm pin, latch pin, comparator pin, ss, capture
    function automatic logic [4:0] exp_status(input logic [7:0] v, input logic [5:0] l);
        return {l[v[4] ? 4 : 5], l[v[3] ? 2 : 3], l[v[2] ? 2 : 3], l[v[1] ? 2 : 3],
            l[v[0] ? 0 : 1]};
    endfunction : exp_status
    task automatic cmp_pins();
        e = exp_pins(s, periph, en);
        lv = (e[5:0] & ~e[11:6]) | (ext & e[11:6]);
        check({26'h0, p_oe_n}, {26'h0, e[11:6]});
        check({26'h0, p_out & ~p_oe_n}, {26'h0, e[5:0] & ~e[11:6]});
        check({31'h0, ss_in}, {31'h0, s[1] ? lv[2] : lv[3]});
        check({31'h0, cap_in}, {31'h0, s[0] ? lv[0] : lv[1]});
    endtask : cmp_pins
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        wb(1'b0, apsel_pkg::apsel_addr_select, 4'hf, 8'h00);
        check(rd, {24'h0, apsel_pkg::apsel_select_reset});
        // upper bits dropped, lane-disabled and status writes ignored
        wb(1'b1, apsel_pkg::apsel_addr_select, 4'h1, 8'hff);
        wb(1'b1, apsel_pkg::apsel_addr_select, 4'he, 8'h00);
        wb(1'b1, apsel_pkg::apsel_addr_status, 4'h1, 8'h00);
        wb(1'b0, apsel_pkg::apsel_addr_select, 4'hf, 8'h00);
        check(rd, {24'h0, apsel_pkg::apsel_select_mask});
        wb(1'b0, 4'h8, 4'hf, 8'h00); // unmapped place answers with err
        check({31'h0, fl}, 32'h1);
        $display("register tests done");
        // every select value first, then random ones
        for (int k = 0; k < 64; k++) begin
            s = (k < 32) ? 8'(k) : 8'($random(seed));
            periph <= 4'($random(seed));
            ext <= 6'($random(seed));
            en <= (k < 32) ? 1'b1 : 1'($random(seed));
            wb(1'b1, apsel_pkg::apsel_addr_select, 4'h1, s);
            repeat (4) @(posedge sys_clk);
            cmp_pins();
            wb(1'b0, apsel_pkg::apsel_addr_select, 4'hf, 8'h00);
            check(rd, {24'h0, s & apsel_pkg::apsel_select_mask});
            wb(1'b0, apsel_pkg::apsel_addr_status, 4'hf, 8'h00);
            check(rd, {27'h0, exp_status(s, lv)});
        end
        $display("routing tests done");
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
